// *** core/dmhbp_pkg.sv ***
// Purpose: Shared constants for the dual mode host bus port
// Assumes: Controller clock of 100 MHz, host bus clock sampled as a plain input
// Notes: Timing counts are in controller clock periods
package dmhbp_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned IDX_W = 8;
  // ----------------------------------------------------------------
  // Timing in controller clock periods
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HOST_BUS_CLOCK_LOW_MIN_CC = 1;
  localparam int unsigned HOST_BUS_CLOCK_HIGH_MIN_CC = 4;
  localparam int unsigned RD_VALID_MIN_CC = 2;
  localparam int unsigned RD_VALID_MAX_CC = 3;
  localparam int unsigned WR_HOLD_MIN_CC = 3;
  localparam int unsigned STRETCH_PERIODS = 3;
  // Host bus clock: max 8 MHz, period 125 ns
  localparam int unsigned HBCLK_MAX_MHZ = 8;
  localparam int unsigned HBCLK_MIN_PERIOD_NS = 1000 / HBCLK_MAX_MHZ;
  localparam int unsigned HBCLK_HALF_CC =
    (HBCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  // Host side high phase: base half period plus stretch
  localparam int unsigned HOST_HIGH_CC = HBCLK_HALF_CC + STRETCH_PERIODS;
  localparam int unsigned HOST_LOW_CC = HBCLK_HALF_CC;
  // Async strobe hold on the host side
  localparam int unsigned AMI_STROBE_CC = 16;
  localparam int unsigned CNT_W = 5;
endpackage

// *** core/dmhbp_if.sv ***
// Purpose: Pin level carrier between host and port
// Assumes: Output enables are active low
// Notes: Wire levels of the shared data bus are resolved by the bench
`timescale 1ns/10ps
`default_nettype none
interface dmhbp_if;
  // ----------------------------------------------------------------
  // Async memory pins
  // ----------------------------------------------------------------
  logic sel_b;
  logic wr_b;
  logic oe_b;
  logic [dmhbp_pkg::ADDR_W-1:0] addr;
  // ----------------------------------------------------------------
  // Synchronous pins
  // ----------------------------------------------------------------
  logic host_bus_clock;
  logic rd_not_wr;
  logic low_byte_strobe;
  // Shared data pins: data out and output enable per end, one resolved input
  logic [dmhbp_pkg::DATA_W-1:0] dev_dout;
  logic dev_doe_b;
  logic [dmhbp_pkg::DATA_W-1:0] host_dout;
  logic host_doe_b;
  logic [dmhbp_pkg::DATA_W-1:0] data_in;
  modport dev (
    input sel_b, wr_b, oe_b, addr, host_bus_clock, rd_not_wr, low_byte_strobe, data_in,
    output dev_dout, dev_doe_b
  );
  modport host (
    output sel_b, wr_b, oe_b, addr, host_bus_clock, rd_not_wr, low_byte_strobe,
    output host_dout, host_doe_b,
    input data_in
  );
endinterface
`default_nettype wire

// *** core/dmhbp_dev.sv ***
// Purpose: Device end of the dual mode host bus port with a word store
// Assumes: All bus pins come from outside and pass two flip-flops; the mode strap is caught in one
// Notes: Mode pin is strapped and caught once after reset release
//
// Summary of operation
// - Async: select and write low writes
// - Async: select, output enable low, write high reads
// - Data pins released unless a read drives
// - Sync bus follows host clock, both edges sampled
// - Host stretches clock high phase three controller clock periods
// - Host clock low at least one period
// - Host clock high at least four periods
// - Read data valid two to three periods
// - Host holds write data three periods
// - Address and low strobe captured on rise
`timescale 1ns/10ps
`default_nettype none
module dmhbp_dev #(
  parameter int unsigned DEPTH = dmhbp_pkg::MEM_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic async_memory_mode,
  dmhbp_if.dev bus,
  output logic wr_pulse,
  output logic [dmhbp_pkg::ADDR_W-1:0] wr_addr,
  output logic [dmhbp_pkg::DATA_W-1:0] wr_data,
  output logic wr_low_only,
  output logic rd_pulse,
  output logic mode_async
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned SW = 4 + dmhbp_pkg::ADDR_W + dmhbp_pkg::DATA_W + 2;
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  wire [SW-1:0] pins = {bus.sel_b, bus.wr_b, bus.oe_b, bus.host_bus_clock,
    bus.addr, bus.data_in, bus.rd_not_wr, bus.low_byte_strobe};
  // Reset to the idle pin levels, host clock low, so no false edge follows reset
  localparam logic [SW-1:0] SYNC_IDLE = {3'h7, 1'b0, {(SW-6){1'b0}}, 2'h3};
  // Two stages; only the second stage is read by logic
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s1_r <= SYNC_IDLE;
      s2_r <= SYNC_IDLE;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end
  wire sel_b_s = s2_r[SW-1];
  wire wr_b_s = s2_r[SW-2];
  wire oe_b_s = s2_r[SW-3];
  wire hclk_s = s2_r[SW-4];
  wire [dmhbp_pkg::ADDR_W-1:0] addr_s = s2_r[SW-5 -: dmhbp_pkg::ADDR_W];
  wire [dmhbp_pkg::DATA_W-1:0] din_s = s2_r[dmhbp_pkg::DATA_W+1:2];
  wire rnw_s = s2_r[1];
  wire lstb_s = s2_r[0];
  // ----------------------------------------------------------------
  // Mode strap
  // ----------------------------------------------------------------
  logic mode_taken_r;
  logic mode_r;
  // Caught once after release so the mode cannot move mid access
  // A strap change takes effect only through another reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_taken_r <= 1'b0;
      mode_r <= 1'b1;
    end else if (!mode_taken_r) begin
      mode_taken_r <= 1'b1;
      mode_r <= async_memory_mode;
    end
  end
  // ----------------------------------------------------------------
  // Async decode
  // ----------------------------------------------------------------
  wire a_wr = mode_taken_r && mode_r && !sel_b_s && !wr_b_s;
  wire a_rd = mode_taken_r && mode_r && !sel_b_s && !oe_b_s && wr_b_s;
  logic a_wr_d_r;
  logic a_rd_d_r;
  // Write commits when a strobe ends, so data set up to write end is used
  wire a_wr_end = a_wr_d_r && !a_wr;
  wire a_rd_start = a_rd && !a_rd_d_r;
  // Address and data are caught while the strobe is low; the host may release
  // the data lines with the strobe, so the strobe end alone comes too late
  logic [dmhbp_pkg::ADDR_W-1:0] a_wa_r;
  logic [dmhbp_pkg::DATA_W-1:0] a_wd_r;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      a_wa_r <= '0;
      a_wd_r <= '0;
    end else if (a_wr) begin
      a_wa_r <= addr_s;
      a_wd_r <= din_s;
    end
  end
  // ----------------------------------------------------------------
  // Sync decode
  // ----------------------------------------------------------------
  // Edges are found on the synchronised copy; a low phase shorter than one
  // period can vanish in the synchroniser, which is why the host must obey it
  logic hclk_d_r;
  wire h_rise = mode_taken_r && !mode_r && hclk_s && !hclk_d_r;
  wire h_fall = mode_taken_r && !mode_r && !hclk_s && hclk_d_r;
  logic [dmhbp_pkg::ADDR_W-1:0] s_addr_r;
  logic s_lstb_r;
  logic s_rnw_r;
  logic s_act_r;
  logic [dmhbp_pkg::CNT_W-1:0] hi_cnt_r;
  // Write data taken from pins sampled inside the host's hold window; the two
  // synchroniser stages add two periods, so one count reaches the third period
  wire s_wr_take = s_act_r && !s_rnw_r &&
    hi_cnt_r == dmhbp_pkg::CNT_W'(dmhbp_pkg::WR_HOLD_MIN_CC - 2);
  // Read drive starts at the detected rise: two synchroniser stages plus the
  // output flop put data on the pins three periods after the host's rise.
  // Any later start would miss the window, so no extra stage fits here.
  wire s_rd_go = h_rise && rnw_s;
  // ----------------------------------------------------------------
  // Word store
  // ----------------------------------------------------------------
  // No reset on the store; a word read before it is written is undefined
  logic [dmhbp_pkg::DATA_W-1:0] mem_r [DEPTH];
  wire do_wr = a_wr_end || s_wr_take;
  wire [dmhbp_pkg::ADDR_W-1:0] w_addr = mode_r ? a_wa_r : s_addr_r;
  wire [dmhbp_pkg::DATA_W-1:0] w_data = mode_r ? a_wd_r : din_s;
  wire w_low = mode_r ? 1'b0 : (s_lstb_r == 1'b0 && w_addr[0]);
  wire [dmhbp_pkg::IDX_W-1:0] w_idx = w_addr[dmhbp_pkg::IDX_W-1:0];
  // Sync reads load the output only at the detected rise, so the live address fits
  wire [dmhbp_pkg::ADDR_W-1:0] r_addr = addr_s;
  wire [dmhbp_pkg::DATA_W-1:0] r_word = mem_r[r_addr[dmhbp_pkg::IDX_W-1:0]];
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem_r[w_idx] <= w_data;
    end
  end
  // ----------------------------------------------------------------
  // Sequencing and pin drive
  // ----------------------------------------------------------------
  logic [dmhbp_pkg::DATA_W-1:0] dout_r;
  logic doe_b_r;
  // Async drive follows the decode; sync drive holds from rise to fall
  wire a_drive = a_rd; // released on unselect, oe high or write
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      a_wr_d_r <= 1'b0;
      a_rd_d_r <= 1'b0;
      hclk_d_r <= 1'b0;
      s_addr_r <= '0;
      s_lstb_r <= 1'b1;
      s_rnw_r <= 1'b1;
      s_act_r <= 1'b0;
      hi_cnt_r <= '0;
      dout_r <= '0;
      doe_b_r <= 1'b1;
    end else begin
      a_wr_d_r <= a_wr;
      a_rd_d_r <= a_rd;
      hclk_d_r <= hclk_s;
      if (h_rise) begin
        s_addr_r <= addr_s;
        s_lstb_r <= lstb_s;
        s_rnw_r <= rnw_s;
        s_act_r <= 1'b1;
        hi_cnt_r <= '0;
      end else if (h_fall) begin
        s_act_r <= 1'b0;
      end else if (s_act_r) begin
        hi_cnt_r <= hi_cnt_r + 1'b1;
      end
      if (mode_r) begin
        doe_b_r <= !a_drive;
        dout_r <= r_word;
      end else if (s_rd_go) begin
        doe_b_r <= 1'b0;
        dout_r <= r_word;
      end else if (h_fall || !s_act_r) begin
        doe_b_r <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // User side notices
  // ----------------------------------------------------------------
  // Registered so the local side sees one clean pulse per access
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_pulse <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_low_only <= 1'b0;
      rd_pulse <= 1'b0;
      mode_async <= 1'b1;
    end else begin
      wr_pulse <= do_wr;
      wr_addr <= do_wr ? w_addr : wr_addr;
      wr_data <= do_wr ? w_data : wr_data;
      wr_low_only <= do_wr ? w_low : wr_low_only;
      rd_pulse <= a_rd_start || s_rd_go;
      mode_async <= mode_r;
    end
  end
  assign bus.dev_dout = dout_r;
  assign bus.dev_doe_b = doe_b_r;
endmodule // dmhbp_dev
`default_nettype wire

// *** core/dmhbp_host.sv ***
// Purpose: Host end driving either bus personality
// Assumes: Same controller clock; requests come from local logic
// Notes: Host bus clock is made here by a divider and stretched
`timescale 1ns/10ps
`default_nettype none
module dmhbp_host (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic use_async,
  input wire logic req,
  input wire logic req_wr,
  input wire logic req_low,
  input wire logic [dmhbp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [dmhbp_pkg::DATA_W-1:0] req_wdata,
  dmhbp_if.host bus,
  output logic busy,
  output logic done,
  output logic [dmhbp_pkg::DATA_W-1:0] rdata
);
  typedef enum logic [1:0] {DMHBP_IDLE, DMHBP_LOW, DMHBP_HIGH} dmhbp_state_e;
  dmhbp_state_e st_r;
  logic [dmhbp_pkg::CNT_W-1:0] cnt_r;
  logic mode_r;
  logic wr_r;
  logic low_r;
  logic [dmhbp_pkg::ADDR_W-1:0] addr_r;
  logic [dmhbp_pkg::DATA_W-1:0] wd_r;
  logic [dmhbp_pkg::DATA_W-1:0] din1_r;
  logic [dmhbp_pkg::DATA_W-1:0] din2_r;
  // ----------------------------------------------------------------
  // Phase lengths
  // ----------------------------------------------------------------
  // Low phase is far above one period; high includes the stretch
  wire [dmhbp_pkg::CNT_W-1:0] low_last = dmhbp_pkg::CNT_W'(dmhbp_pkg::HOST_LOW_CC - 1);
  wire [dmhbp_pkg::CNT_W-1:0] high_last = mode_r ?
    dmhbp_pkg::CNT_W'(dmhbp_pkg::AMI_STROBE_CC - 1) :
    dmhbp_pkg::CNT_W'(dmhbp_pkg::HOST_HIGH_CC - 1);
  wire phase_end = cnt_r == (st_r == DMHBP_LOW ? low_last : high_last);
  // Read data synchronised before use
  always_ff @(posedge core_clk) begin
    din1_r <= bus.data_in;
    din2_r <= din1_r;
  end
  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_r <= DMHBP_IDLE;
      cnt_r <= '0;
      mode_r <= 1'b1;
      wr_r <= 1'b0;
      low_r <= 1'b0;
      addr_r <= '0;
      wd_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
    end else begin
      done <= 1'b0;
      case (st_r)
        DMHBP_IDLE: begin
          cnt_r <= '0;
          if (req) begin
            mode_r <= use_async;
            wr_r <= req_wr;
            low_r <= req_low;
            addr_r <= req_addr;
            wd_r <= req_wdata;
            busy <= 1'b1;
            st_r <= DMHBP_LOW;
          end
        end
        DMHBP_LOW: begin
          cnt_r <= phase_end ? '0 : cnt_r + 1'b1;
          if (phase_end) begin
            st_r <= DMHBP_HIGH;
          end
        end
        DMHBP_HIGH: begin
          cnt_r <= phase_end ? '0 : cnt_r + 1'b1;
          if (phase_end) begin
            rdata <= din2_r;
            busy <= 1'b0;
            done <= 1'b1;
            st_r <= DMHBP_IDLE;
          end
        end
        default: begin
          st_r <= DMHBP_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  wire in_high = st_r == DMHBP_HIGH;
  wire act = st_r != DMHBP_IDLE;
  logic sel_b_r;
  logic wr_b_r;
  logic oe_b_r;
  logic hclk_r;
  logic rnw_r;
  logic lstb_r;
  logic doe_b_r;
  // Pins leave through flip-flops so no state decode glitch reaches the far end;
  // strobe, clock and enable pins move one cycle after the state; address and write data move with the state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sel_b_r <= 1'b1;
      wr_b_r <= 1'b1;
      oe_b_r <= 1'b1;
      hclk_r <= 1'b0;
      rnw_r <= 1'b1;
      lstb_r <= 1'b1;
      doe_b_r <= 1'b1;
    end else begin
      sel_b_r <= !(mode_r && in_high);
      wr_b_r <= !(mode_r && in_high && wr_r);
      oe_b_r <= !(mode_r && in_high && !wr_r);
      hclk_r <= !mode_r && in_high;
      rnw_r <= !wr_r;
      lstb_r <= !low_r;
      doe_b_r <= !(act && wr_r); // Held through the whole high phase
    end
  end
  assign bus.sel_b = sel_b_r;
  assign bus.wr_b = wr_b_r;
  assign bus.oe_b = oe_b_r;
  assign bus.addr = addr_r;
  assign bus.host_bus_clock = hclk_r;
  assign bus.rd_not_wr = rnw_r;
  assign bus.low_byte_strobe = lstb_r;
  assign bus.host_dout = wd_r;
  assign bus.host_doe_b = doe_b_r;
endmodule // dmhbp_host
`default_nettype wire

// *** tb/dmhbp_properties.sv ***
// Purpose: Pin level properties of the host bus port carrier
// Assumes: Output enables are low while an end drives the data lines
// Notes: Windows are counted in controller clock cycles
`timescale 1ns/10ps
`default_nettype none
module dmhbp_properties (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sel_b,
  input wire logic wr_b,
  input wire logic oe_b,
  input wire logic [dmhbp_pkg::ADDR_W-1:0] addr,
  input wire logic host_bus_clock,
  input wire logic rd_not_wr,
  input wire logic low_byte_strobe,
  input wire logic dev_doe_b,
  input wire logic [dmhbp_pkg::DATA_W-1:0] host_dout,
  input wire logic host_doe_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------------------
  // Host clock shape
  // ------------------------------------------------------------
  // Low 7, high 10: the high phase carries the 3 cycle stretch
  sequence low_phase;
    !host_bus_clock[*7];
  endsequence
  sequence high_phase;
    host_bus_clock[*8] ##1 host_bus_clock[*2] ##1 !host_bus_clock;
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  clk_low_a: assert property ($fell(host_bus_clock) |-> low_phase)
    else $error("host clock low phase too short");
  clk_high_a: assert property ($rose(host_bus_clock) |-> high_phase)
    else $error("host clock high phase wrong length");
  wr_hold_a: assert property ($rose(host_bus_clock) && !rd_not_wr |=>
    (!host_doe_b && $stable(host_dout))[*3]) else $error("write data not held");
  addr_hold_a: assert property ($rose(host_bus_clock) |=>
    ($stable(addr) && $stable(low_byte_strobe) && $stable(rd_not_wr))[*3])
    else $error("address moved after clock rise");
  sync_read_a: assert property ($rose(host_bus_clock) && rd_not_wr |->
    dev_doe_b ##1 dev_doe_b ##[1:2] !dev_doe_b) else $error("read data window missed");
  async_rd_a: assert property ((!sel_b && !oe_b && wr_b)[*5] |-> !dev_doe_b)
    else $error("async read not driven");
  async_wr_a: assert property ($fell(wr_b) |-> (!sel_b && oe_b && !host_doe_b)[*8])
    else $error("async write strobe malformed");
  wr_hiz_a: assert property (!sel_b && !wr_b |-> dev_doe_b)
    else $error("device drives during write");
  idle_hiz_a: assert property ((sel_b && !host_bus_clock)[*6] |-> dev_doe_b)
    else $error("device drives while idle");
  no_fight_a: assert property (!(!dev_doe_b && !host_doe_b))
    else $error("both ends drive data");
endmodule // dmhbp_properties
`default_nettype wire

// *** tb/dual_mode_host_bus_port_tb.sv ***
// Purpose: Self-checking bench joining host end and device end
// Assumes: Strap is changed only while reset is held
// Notes: Released data lines show a moving pattern, not the last word
`timescale 1ns/10ps
`default_nettype none
module dual_mode_host_bus_port_tb;
  typedef logic [dmhbp_pkg::DATA_W-1:0] dmhbp_word_t;
  logic core_clk;
  logic rst_b;
  logic strap;
  logic req, req_wr, req_low, busy, done;
  dmhbp_word_t req_addr, req_wdata, rdata, wr_addr, wr_data;
  logic wr_pulse, wr_low_only, rd_pulse, mode_async;
  logic [31:0] cyc = 32'h0;
  int n_errors = 0, checks = 0, n_wr = 0, n_rd = 0;
  dmhbp_word_t ta[3] = '{16'h0012, 16'h0013, 16'h00ff};
  dmhbp_word_t td[3] = '{16'ha5c3, 16'h3c5a, 16'h8001};
  dmhbp_if bif();
  // Wire level from both enables; nobody driving gives a changing word
  assign bif.data_in = !bif.dev_doe_b ? bif.dev_dout :
    !bif.host_doe_b ? bif.host_dout : ~cyc[15:0];
  dmhbp_dev dmhbp_dev_inst (.core_clk(core_clk), .rst_b(rst_b), .async_memory_mode(strap),
    .bus(bif), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_low_only(wr_low_only), .rd_pulse(rd_pulse), .mode_async(mode_async));
  dmhbp_host dmhbp_host_inst (.core_clk(core_clk), .rst_b(rst_b), .use_async(strap),
    .req(req), .req_wr(req_wr), .req_low(req_low), .req_addr(req_addr),
    .req_wdata(req_wdata), .bus(bif), .busy(busy), .done(done), .rdata(rdata));
  dmhbp_properties dmhbp_properties_inst (.core_clk(core_clk), .rst_b(rst_b),
    .sel_b(bif.sel_b), .wr_b(bif.wr_b), .oe_b(bif.oe_b), .addr(bif.addr),
    .host_bus_clock(bif.host_bus_clock), .rd_not_wr(bif.rd_not_wr),
    .low_byte_strobe(bif.low_byte_strobe), .dev_doe_b(bif.dev_doe_b),
    .host_dout(bif.host_dout), .host_doe_b(bif.host_doe_b));
  // ------------------------------------------------------------
  // Clock, pulse counters and hang guard
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Ceiling far above the roughly 300 cycles the tests need
  always @(posedge core_clk) begin
    cyc <= cyc + 32'h1;
    if (wr_pulse === 1'b1) n_wr++;
    if (rd_pulse === 1'b1) n_rd++;
    if (cyc == 32'h1388) begin
      n_errors++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input dmhbp_word_t exp, input dmhbp_word_t got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One access; d is write data, or the expected word for a read
  task automatic xfer(input logic w, input logic lo, input dmhbp_word_t a,
    input dmhbp_word_t d);
    int k;
    int nw;
    int nr;
    nw = n_wr;
    nr = n_rd;
    @(negedge core_clk);
    req = 1'b1;
    req_wr = w;
    req_low = lo;
    req_addr = a;
    req_wdata = d;
    @(negedge core_clk);
    req = 1'b0;
    chk("busy", 16'h1, {15'h0, busy});
    k = 0;
    while (done !== 1'b1 && k < 60) begin
      @(negedge core_clk);
      k++;
    end
    chk("done", 16'h1, {15'h0, done});
    chk("access cycles", dmhbp_word_t'(dmhbp_pkg::HOST_LOW_CC +
      (strap ? dmhbp_pkg::AMI_STROBE_CC : dmhbp_pkg::HOST_HIGH_CC)), dmhbp_word_t'(k));
    chk("busy idle", 16'h0, {15'h0, busy});
    k = 0;
    // Async writes commit only after the strobe ends, so allow a few cycles
    while (w && n_wr == nw && k < 20) begin
      @(negedge core_clk);
      k++;
    end
    if (w) begin
      chk("write count", dmhbp_word_t'(nw + 1), dmhbp_word_t'(n_wr));
      chk("wr_addr", a, wr_addr);
      chk("wr_data", d, wr_data);
      chk("wr_low_only", {15'h0, lo && !strap}, {15'h0, wr_low_only});
    end else begin
      chk("read count", dmhbp_word_t'(nr + 1), dmhbp_word_t'(n_rd));
      chk("rdata", d, rdata);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence: synchronous mode first, then async memory mode
  // ------------------------------------------------------------
  initial begin
    req = 1'b0;
    req_wr = 1'b0;
    req_low = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    for (int m = 0; m < 2; m++) begin
      strap = m[0];
      rst_b = 1'b0;
      repeat (8) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge core_clk);
      chk("mode_async", {15'h0, m[0]}, {15'h0, mode_async});
      // Back to back writes, odd address with the low strobe, top index
      for (int i = 0; i < 3; i++) xfer(1'b1, i == 1, ta[i], td[i] ^ {16{m[0]}});
      for (int i = 2; i >= 0; i--) xfer(1'b0, 1'b0, ta[i], td[i] ^ {16{m[0]}});
    end
    close_out();
  end
endmodule // dual_mode_host_bus_port_tb
`default_nettype wire
